// [bench/gpio_port_assertions.sv]
// concurrent checks on the pad port boundary
`timescale 1ns/100ps
module gpio_port_chk
    import gpio_port_pkg::*;
#(parameter int NPRI = 10, parameter int NEXT = 17) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [NPRI+NEXT-1:0] pad_in,
    input wire logic [NPRI+NEXT-1:0] pad_out,
    input wire logic [NPRI+NEXT-1:0] pad_oe,
    input wire logic [2*(NPRI+NEXT)-1:0] role_cfg,
    input wire logic [NPRI+NEXT-1:0] out_value,
    input wire logic [NPRI+NEXT-1:0] read_value,
    input wire logic [NEXT-1:0] periph_oe,
    input wire logic [NEXT-1:0] periph_release,
    input wire logic [NPRI+NEXT-1:0] irq_clear,
    input wire logic [NPRI+NEXT-1:0] irq_pending,
    input wire logic irq_any,
    input wire logic wake_line_one_en,
    input wire logic wake_line_four_en,
    input wire logic wake_line_five_en,
    input wire logic wake_line_eight_en,
    input wire logic wake_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // role of pad 0, the pad watched in detail
    wire logic [1:0] r0 = role_cfg[1:0];
    // no wake enable set at all
    wire logic wake_off = !wake_line_one_en && !wake_line_four_en
        && !wake_line_five_en && !wake_line_eight_en;
    a_any_or: assert property (irq_any == |irq_pending)
        else $error("summary flag differs from pending flags");
    a_out_drive: assert property (r0 == ROLE_OUTPUT |=> pad_oe[0]
        && pad_out[0] == $past(out_value[0])) else $error("output drive");
    a_in_float: assert property (r0 == ROLE_INPUT |=> !pad_oe[0])
        else $error("input pad driven");
    a_read_out: assert property (r0 == ROLE_OUTPUT
        |=> read_value[0] == $past(out_value[0])) else $error("readback");
    a_read_sync: assert property ((r0 == ROLE_INPUT) [*3]
        |=> read_value[0] == $past(pad_in[0], 3)) else $error("sync read");
    a_pend_hold: assert property (irq_pending[0] && !irq_clear[0]
        |=> irq_pending[0]) else $error("pending lost");
    a_pend_input: assert property ((r0 != ROLE_INPUT) [*6]
        |=> !$rose(irq_pending[0])) else $error("flag on non-input");
    a_periph_own: assert property (!periph_release[0]
        |=> pad_oe[NPRI] == $past(periph_oe[0])) else $error("periph");
    a_wake_idle: assert property (wake_off [*2]
        |=> !wake_request) else $error("wake with all enables off");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk #(.NPRI(NPRI), .NEXT(NEXT)) u_chk (.*);

// [bench/module_gpio_port_tb.sv]
// self-checking bench for the pad port
`timescale 1ns/100ps
module module_gpio_port_tb;
    import gpio_port_pkg::*;
    localparam int N = TOTAL_PADS;
    logic clk_sys = 0, resetn = 0, i2c_enable = 0, i2c_scl_low = 0;
    logic i2c_sda_low = 0, i2c_scl_in, i2c_sda_in, irq_any, wake_request;
    logic wake_line_one_en = 0, wake_line_four_en = 0;
    logic wake_line_five_en = 0, wake_line_eight_en = 0;
    logic [N-1:0] out_value = '0, alt_out = '0, alt_oe = '0, drv = '0;
    logic [N-1:0] irq_enable = '0, irq_clear = '0, r, s, exp_oe, exp_v;
    logic [N-1:0] pad_in, pad_out, pad_oe, read_value, alt_in, irq_pending;
    logic [2*N-1:0] role_cfg = '0, rc;
    logic [EXTRA_PADS-1:0] periph_out = '0, periph_oe = '0, periph_in;
    logic [EXTRA_PADS-1:0] periph_release = '1;
    logic [I2C_SEL_W-1:0] i2c_scl_sel = 4'h2, i2c_sda_sel = 4'h5;
    logic [15:0] lfsr = 16'hC064;
    int miscompares = 0, comparisons = 0, wk;
    gpio_port u_gpio_port (.*);
    pad_devices #(.N(N)) u_pad_devices (.resetn(resetn), .pad_out(pad_out),
        .pad_oe(pad_oe), .drive(drv), .pad_in(pad_in));
    always #5 clk_sys = ~clk_sys;
    // fixed-seed random bits, one lfsr step per bit
    function automatic logic [N-1:0] rnd();
        for (int i = 0; i < N; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            rnd[i] = lfsr[0];
        end
    endfunction : rnd
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // watchdog so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        chk({pad_oe, irq_pending, wake_request}, '0);
        chk(i2c_scl_in, 1'b1);
        resetn <= 1'b1;
        // random mix of input, output and alternate roles
        repeat (12) begin
            r = rnd();
            s = rnd();
            for (int i = 0; i < N; i++) begin
                rc[2*i +: 2] = s[i] ? ROLE_ALT : {1'b0, r[i]};
            end
            role_cfg <= rc;
            out_value <= rnd();
            alt_out <= rnd();
            alt_oe <= rnd();
            drv <= rnd();
            repeat (6) @(posedge clk_sys);
            // expected enable and pad level from each pad's role
            exp_oe = (s & alt_oe) | (~s & r);
            exp_v = (s & alt_out) | (~s & out_value);
            exp_v = (exp_oe & exp_v) | (~exp_oe & drv);
            chk(pad_oe, exp_oe);
            chk(pad_out & exp_oe, exp_v & exp_oe);
            chk(read_value, exp_v);
            chk(alt_in, exp_v);
            chk(periph_in, exp_v[N-1:PRIMARY_PADS]);
        end
        // extra pads handed back to their peripheral
        periph_release <= '0;
        periph_oe <= rnd();
        periph_out <= rnd();
        repeat (3) @(posedge clk_sys);
        exp_oe = {periph_oe, {PRIMARY_PADS{1'b0}}};
        exp_v = {periph_out, {PRIMARY_PADS{1'b0}}} & exp_oe;
        chk(pad_oe[N-1:PRIMARY_PADS], periph_oe);
        chk(pad_out & exp_oe, exp_v);
        // emulated i2c master on pads 2 and 5
        rc = '0;
        rc[5:4] = ROLE_I2C;
        rc[11:10] = ROLE_I2C;
        role_cfg <= rc;
        {i2c_enable, i2c_scl_low, drv} <= {2'h3, N'('1)};
        repeat (6) @(posedge clk_sys);
        chk({pad_oe[2], pad_out[2], i2c_scl_in}, 3'h4);
        chk({pad_oe[5], i2c_sda_in}, 2'h1);
        // change flags and wake on each primary pad
        role_cfg <= '0;
        {i2c_enable, drv, irq_enable} <= {1'b0, N'(0), N'('1)};
        {wake_line_one_en, wake_line_four_en} <= 2'h3;
        {wake_line_five_en, wake_line_eight_en} <= 2'h3;
        for (int p = 0; p < PRIMARY_PADS; p++) begin
            irq_clear <= '1;
            repeat (8) @(posedge clk_sys);
            chk({irq_any, irq_pending}, '0);
            irq_clear <= '0;
            drv[p] <= 1'b1;
            wk = 0;
            repeat (8) @(posedge clk_sys) wk += wake_request;
            chk(irq_pending, N'(1) << p);
            chk(irq_any, 1'b1);
            chk(wk, p == 0 || p == 3 || p == 4 || p == 7);
            drv[p] <= 1'b0;
        end
        results();
    end
endmodule : module_gpio_port_tb

// [bench/pad_devices.sv]
// external devices wired to the pads
`timescale 1ns/100ps
module pad_devices #(parameter int N = 27) (
    input wire logic resetn,
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe,
    input wire logic [N-1:0] drive,
    output logic [N-1:0] pad_in
);
    // push-pull module drive wins; board keeps straps low in reset
    assign pad_in = (pad_oe & pad_out)
        | (~pad_oe & drive & {N{resetn}});
endmodule : pad_devices

// [core/gpio_port.sv]
// general-purpose pad port with roles, change interrupts and wake
`timescale 1ns/100ps
module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int NPRI = PRIMARY_PADS,
    parameter int NEXT = EXTRA_PADS
) (
    // clock and synchronous reset
    input wire logic clk_sys,
    input wire logic resetn,
    // pad side: levels in, drive data and enable out
    input wire logic [NPRI+NEXT-1:0] pad_in,
    output logic [NPRI+NEXT-1:0] pad_out,
    output logic [NPRI+NEXT-1:0] pad_oe,
    // role selection and software data
    input wire logic [2*(NPRI+NEXT)-1:0] role_cfg,
    input wire logic [NPRI+NEXT-1:0] out_value,
    output logic [NPRI+NEXT-1:0] read_value,
    // firmware alternate source
    input wire logic [NPRI+NEXT-1:0] alt_out,
    input wire logic [NPRI+NEXT-1:0] alt_oe,
    output logic [NPRI+NEXT-1:0] alt_in,
    // initial peripheral of the extra pads
    input wire logic [NEXT-1:0] periph_out,
    input wire logic [NEXT-1:0] periph_oe,
    output logic [NEXT-1:0] periph_in,
    input wire logic [NEXT-1:0] periph_release,
    // emulated i2c master, low-only drive
    input wire logic i2c_enable,
    input wire logic [I2C_SEL_W-1:0] i2c_scl_sel,
    input wire logic [I2C_SEL_W-1:0] i2c_sda_sel,
    input wire logic i2c_scl_low,
    input wire logic i2c_sda_low,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    // change interrupts
    input wire logic [NPRI+NEXT-1:0] irq_enable,
    input wire logic [NPRI+NEXT-1:0] irq_clear,
    output logic [NPRI+NEXT-1:0] irq_pending,
    output logic irq_any,
    // wake-up from sleep, four capable lines only
    input wire logic wake_line_one_en,
    input wire logic wake_line_four_en,
    input wire logic wake_line_five_en,
    input wire logic wake_line_eight_en,
    output logic wake_request
);
    // pad count across both groups
    localparam int N = NPRI + NEXT;

    // all block state in one record
    typedef struct packed {
        logic [N-1:0] sync1;   // first synchroniser stage
        logic [N-1:0] sync2;   // second stage, the clean level
        logic [N-1:0] last;    // previous clean level for edges
        logic [N-1:0] rd;      // read-back value
        logic [N-1:0] pend;    // sticky change flags
        logic [N-1:0] pout;    // registered pad data
        logic [N-1:0] poe;     // registered pad enable
        logic [NEXT-1:0] pin;  // peripheral input copy
        logic [N-1:0] ain;     // alternate input copy
        logic scl;             // i2c clock level seen
        logic sda;             // i2c data level seen
        logic wake;            // wake request level
        logic [WAKE_LINES-1:0] wen; // wake enables, caught each cycle
    } state_t;

    // registered state and its next value
    state_t s_q;
    state_t s_d;
    logic [1:0] role [N];      // decoded role per pad
    logic [N-1:0] gp_owned;    // pad under general-purpose control
    logic [N-1:0] change;      // edge on clean level
    logic [N-1:0] per_out_w;   // peripheral drive spread over all pads
    logic [N-1:0] per_oe_w;    // peripheral enable spread over all pads

    // unpack role fields; primary pads never lose their role
    always_comb begin
        for (int i = 0; i < N; i++) begin
            role[i] = role_cfg[2*i +: 2];
            // i2c role only defined for the first ten lines
            if (i >= NPRI && role[i] == ROLE_I2C) begin
                role[i] = ROLE_INPUT;
            end
        end
        // primary pads always general purpose; extras once released
        gp_owned = {periph_release, {NPRI{1'b1}}};
    end

    // primary slots padded with zero; never peripheral owned
    assign per_out_w = {periph_out, {NPRI{1'b0}}};
    assign per_oe_w = {periph_oe, {NPRI{1'b0}}};

    // next state
    always_comb begin
        // hold everything not written below
        s_d = s_q;
        // synchroniser: stage one is read only by stage two
        s_d.sync1 = pad_in;
        s_d.sync2 = s_q.sync1;
        // last clean level, for edge detection
        s_d.last = s_q.sync2;
        // both directions count as a change; a pad already high when
        // reset ends shows one change, so clear flags after enabling
        change = s_q.sync2 ^ s_q.last;
        // enables pass one register stage before they gate wake
        s_d.wen = {wake_line_eight_en, wake_line_five_en,
                   wake_line_four_en, wake_line_one_en};
        // released i2c lines read high, as a pulled-up bus would
        s_d.scl = 1'b1;
        s_d.sda = 1'b1;
        for (int i = 0; i < N; i++) begin
            // defaults: pad released, inputs track the clean level
            s_d.pout[i] = 1'b0;
            s_d.poe[i] = 1'b0;
            s_d.ain[i] = s_q.sync2[i];
            s_d.rd[i] = s_q.sync2[i];
            if (!gp_owned[i]) begin
                // peripheral owns the pad until released
                s_d.pout[i] = per_out_w[i];
                s_d.poe[i] = per_oe_w[i];
            end else begin
                unique case (role[i])
                    ROLE_INPUT: begin
                        // never drives; the read shows the pad level
                        s_d.rd[i] = s_q.sync2[i];
                    end
                    ROLE_OUTPUT: begin
                        // push-pull: enable held for both levels
                        s_d.pout[i] = out_value[i];
                        s_d.poe[i] = 1'b1;
                        s_d.rd[i] = out_value[i];
                    end
                    ROLE_ALT: begin
                        // firmware source owns both data and enable
                        s_d.pout[i] = alt_out[i];
                        s_d.poe[i] = alt_oe[i];
                    end
                    ROLE_I2C: begin
                        // open-drain style: only drive low, master only
                        // scl is tested first, so it wins on equal selects
                        if (i2c_enable &&
                            i2c_scl_sel == I2C_SEL_W'(i)) begin
                            s_d.poe[i] = i2c_scl_low;
                            s_d.scl = s_q.sync2[i];
                        end else if (i2c_enable &&
                            i2c_sda_sel == I2C_SEL_W'(i)) begin
                            s_d.poe[i] = i2c_sda_low;
                            s_d.sda = s_q.sync2[i];
                        end
                    end
                    default: begin
                        // unreachable: all four codes are decoded
                        s_d.poe[i] = 1'b0;
                    end
                endcase
            end
            // change flag: set beats a same-cycle clear
            // only general-purpose input pads may flag
            if (gp_owned[i] && role[i] == ROLE_INPUT &&
                irq_enable[i] && change[i]) begin
                s_d.pend[i] = 1'b1;
            end else if (irq_clear[i]) begin
                s_d.pend[i] = 1'b0;
            end
        end
        // peripheral sees the clean level of its pads
        for (int i = 0; i < NEXT; i++) begin
            s_d.pin[i] = s_q.sync2[NPRI+i];
        end
        // wake only from the four capable lines; others ignored
        // a capable line in another role never wakes either
        s_d.wake = (s_q.wen[0] && change[WAKE_IDX_ONE]
                    && role[WAKE_IDX_ONE] == ROLE_INPUT)
                 || (s_q.wen[1] && change[WAKE_IDX_FOUR]
                    && role[WAKE_IDX_FOUR] == ROLE_INPUT)
                 || (s_q.wen[2] && change[WAKE_IDX_FIVE]
                    && role[WAKE_IDX_FIVE] == ROLE_INPUT)
                 || (s_q.wen[3] && change[WAKE_IDX_EIGHT]
                    && role[WAKE_IDX_EIGHT] == ROLE_INPUT);
    end

    // state register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            // everything clear, i2c lines idle high, wake off
            s_q <= '0;
            s_q.scl <= 1'b1;
            s_q.sda <= 1'b1;
            s_q.wen <= {WAKE_LINES{WAKE_EN_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops; irq_any is an OR of them
    assign pad_out = s_q.pout;
    assign pad_oe = s_q.poe;
    assign read_value = s_q.rd;
    assign alt_in = s_q.ain;
    assign periph_in = s_q.pin;
    assign i2c_scl_in = s_q.scl;
    assign i2c_sda_in = s_q.sda;
    assign irq_pending = s_q.pend;
    // summary of all pending flags for a single request line
    assign irq_any = |s_q.pend;
    assign wake_request = s_q.wake;

endmodule : gpio_port

// [core/gpio_port_pkg.sv]
// shared constants for the general-purpose pad port
package gpio_port_pkg;
    // pad counts
    localparam int PRIMARY_PADS = 10;
    localparam int EXTRA_PADS = 17;
    localparam int TOTAL_PADS = PRIMARY_PADS + EXTRA_PADS;
    // role encoding per pad, two bits
    localparam logic [1:0] ROLE_INPUT = 2'h0;
    localparam logic [1:0] ROLE_OUTPUT = 2'h1;
    localparam logic [1:0] ROLE_ALT = 2'h2;
    localparam logic [1:0] ROLE_I2C = 2'h3;
    // wake-capable line indices, zero based (lines 1, 4, 5, 8)
    localparam int WAKE_IDX_ONE = 0;
    localparam int WAKE_IDX_FOUR = 3;
    localparam int WAKE_IDX_FIVE = 4;
    localparam int WAKE_IDX_EIGHT = 7;
    localparam int WAKE_LINES = 4;
    // i2c line index width
    localparam int I2C_SEL_W = 4;
    // reset values
    localparam logic [1:0] ROLE_RESET = ROLE_INPUT;
    localparam logic WAKE_EN_RESET = 1'h0;
    localparam logic IRQ_EN_RESET = 1'h0;
endpackage : gpio_port_pkg
